/* inc/sio_pkg.sv */
package sio_pkg;
  localparam logic [15:0] ADDR_ASYNC_MODE = 16'hff70;
  localparam logic [15:0] ADDR_ERR_STATUS = 16'hff71;
  localparam logic [15:0] ADDR_SYNC_MODE  = 16'hff72;
  localparam logic [15:0] ADDR_BAUD_CTRL  = 16'hff73;
  localparam logic [15:0] ADDR_TX_DATA    = 16'hff74;
  localparam logic [15:0] ADDR_RX_DATA    = 16'hff75;
  localparam logic [15:0] ADDR_BUF_STATUS = 16'hff76;

  localparam int BYTE_W = 8;
  localparam logic [7:0] MODE_RESET    = 8'h00;
  localparam logic [7:0] READ_ZERO     = 8'h00;
  localparam logic [7:0] ASYNC_WR_MASK = 8'hfc;
  localparam logic [7:0] SYNC_WR_MASK  = 8'hcf;
  localparam logic [7:0] BAUD_WR_MASK  = 8'hf0;

  localparam int TXE_BIT  = 7;
  localparam int RXE_BIT  = 6;
  localparam int PAR_HI   = 5;
  localparam int PAR_LO   = 4;
  localparam int CL_BIT   = 3;
  localparam int SL_BIT   = 2;
  localparam int CSIE_BIT = 7;
  localparam int SSE_BIT  = 6;
  localparam int DAP_BIT  = 3;
  localparam int DIR_BIT  = 2;
  localparam int CSCK_BIT = 1;
  localparam int CKP_BIT  = 0;
  localparam int EXT_BIT  = 7;
  localparam int DIV_HI   = 6;
  localparam int DIV_LO   = 4;

  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD  = 2'h2;

  localparam logic [3:0] OVS_LAST   = 4'hf;
  localparam logic [3:0] OVS_MID    = 4'h7;
  localparam logic [3:0] LEN_7      = 4'h7;
  localparam logic [3:0] LEN_8      = 4'h8;
  localparam logic [3:0] CSI_BITS   = 4'h8;
  localparam logic [4:0] CSI_EDGES  = 5'h10;
  localparam logic [8:0] DIV_BASE   = 9'h002;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } sio_bus_req_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_RUN  = 2'b01
  } sio_rx_t;
endpackage

/* verilog/sio_serial_if.sv */
// Functional notes
// - External pin clock baud source gives bit rate of pin frequency over 16.
// - Baud control value 80H selects the external pin clock.
// - Internal 3-wire clock is fx over 2 to the n+2, n 0..7.
// - Slave 3-wire clock from the pin ignores baud control setting.
// - Three modes: stop, asynchronous UART, 3-wire clocked serial.
// - Stop mode transfers nothing and releases clock, out and in pins.
// - Sync mode bit 7 enables 3-wire operation.
// - Async mode bit 7 enables transmission.
// - Async mode bit 6 enables reception.
// - UART sends and receives character after start bit, full duplex.
// - Baud generator can reach 31.25 kbps for MIDI.
// - Sync bit 6 set lets slave-select pin level gate communication.
// - Data phase bit picks falling (0) or rising (1) output edge.
// - Bit order bit picks MSB first (0) or LSB first (1).
// - Clock source bit: 0 external clock pin, 1 baud generator.
// - Polarity bit: 0 idles high, 1 idles low.
// - Parity field: none, zero sent unchecked, odd, even.
// - Character length bit: 7 bits when 0, 8 bits when 1.
// - Stop length bit: transmitter sends 1 or 2 stop bits.
// - Reset clears both mode registers to 00H.
// - Receiver checks only one stop bit.
// - Internal UART rate is fx over 2 to the n+1 times 16.
// - Overrun flagged when reception completes before buffer is read.
module sio_serial_if #(
  parameter int TXQ_DEPTH = 2
) (
  input  wire logic                 core_clk_in,
  input  wire logic                 rst_n_in,
  input  wire sio_pkg::sio_bus_req_t bus_req_in,
  output logic [7:0]                reg_rdata_out,
  output logic                      tx_ready_out,
  input  wire logic                 serial_clock_pin_in,
  output logic                      serial_clock_pin_out,
  output logic                      serial_clock_pin_oe_n_out,
  output logic                      serial_out_pin_out,
  output logic                      serial_out_pin_oe_n_out,
  input  wire logic                 serial_in_pin_in,
  input  wire logic                 slave_select_pin_in,
  output logic                      port_release_out
);
  localparam int PW = (TXQ_DEPTH > 1) ? $clog2(TXQ_DEPTH) : 1;
  localparam int CW = $clog2(TXQ_DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(TXQ_DEPTH);
  typedef struct packed {
    logic [7:0]                     asim;
    logic [7:0]                     csim;
    logic [7:0]                     bgc;
    logic [2:0]                     err;
    logic [7:0]                     rxbuf;
    logic                           rx_full;
    logic [TXQ_DEPTH-1:0][7:0]      txq;
    logic [PW-1:0]                  wp;
    logic [PW-1:0]                  rp;
    logic [CW-1:0]                  cnt;
    logic [7:0]                     pre;
    logic                           clk_prev;
    logic                           rx_prev;
    logic [3:0]                     t_ovs;
    logic [3:0]                     t_left;
    logic [11:0]                    t_sh;
    logic                           txd;
    sio_pkg::sio_rx_t               r_st;
    logic [3:0]                     r_ovs;
    logic [3:0]                     r_idx;
    logic [11:0]                    r_sh;
    logic                           c_act;
    logic                           sck;
    logic [4:0]                     c_edges;
    logic [3:0]                     c_bits;
    logic [7:0]                     c_sh;
    logic                           so;
    logic [7:0]                     rdata;
  } sio_state_t;
  sio_state_t q;
  sio_state_t next_q;
  function automatic logic [7:0] div_mask(input logic [7:0] bgc);
    logic [8:0] m;
    m = (sio_pkg::DIV_BASE << bgc[sio_pkg::DIV_HI:sio_pkg::DIV_LO]) - 9'h001;
    return m[7:0];
  endfunction
  function automatic logic par_bit(input logic [1:0] mode, input logic [7:0] d);
    logic p;
    p = 1'b0;
    if (mode == sio_pkg::PAR_ODD) begin
      p = ~^d;
    end else if (mode != sio_pkg::PAR_ZERO) begin
      p = ^d;
    end
    return p;
  endfunction
  function automatic logic out_bit(input logic [7:0] sh, input logic lsb_first);
    return lsb_first ? sh[0] : sh[7];
  endfunction
  logic       txe, rxe, csie, sse, dap, dir, csck, ckp, cl, sl;
  logic [1:0] pmode;
  logic       has_par;
  logic [3:0] dlen;
  logic       stop_mode;
  logic       tick, pin_rise, pin_fall;
  logic       push, pop, rd_clear;
  logic       rx_done, rx_pe, rx_fe;
  logic [7:0] rx_word, head, dmask;
  logic       comm_ok, e_rise, e_fall, shift_e, sample_e;
  logic [3:0] rx_last;
  assign txe      = q.asim[sio_pkg::TXE_BIT];
  assign rxe      = q.asim[sio_pkg::RXE_BIT];
  assign pmode    = q.asim[sio_pkg::PAR_HI:sio_pkg::PAR_LO];
  assign cl       = q.asim[sio_pkg::CL_BIT];
  assign sl       = q.asim[sio_pkg::SL_BIT];
  assign csie     = q.csim[sio_pkg::CSIE_BIT];
  assign sse      = q.csim[sio_pkg::SSE_BIT];
  assign dap      = q.csim[sio_pkg::DAP_BIT];
  assign dir      = q.csim[sio_pkg::DIR_BIT];
  assign csck     = q.csim[sio_pkg::CSCK_BIT];
  assign ckp      = q.csim[sio_pkg::CKP_BIT];
  assign has_par  = (pmode != sio_pkg::PAR_NONE);
  assign dlen     = cl ? sio_pkg::LEN_8 : sio_pkg::LEN_7;
  assign dmask    = cl ? 8'hff : 8'h7f;
  assign rx_last  = dlen + {3'h0, has_par} + 4'h1;
  assign head     = q.txq[q.rp];
  assign stop_mode = ~csie & ~txe & ~rxe;
  assign comm_ok  = ~sse | ~slave_select_pin_in;
  assign pin_rise = serial_clock_pin_in & ~q.clk_prev;
  assign pin_fall = ~serial_clock_pin_in & q.clk_prev;
  // 16x tick: 80H takes pin rising edges, else fx over 2^(n+1) (bit = 16 ticks)
  assign tick = q.bgc[sio_pkg::EXT_BIT] ? pin_rise :
                ((q.pre & div_mask(q.bgc)) == div_mask(q.bgc));
  always_comb begin
    next_q   = q;
    push     = 1'b0;
    pop      = 1'b0;
    rd_clear = 1'b0;
    rx_done  = 1'b0;
    rx_pe    = 1'b0;
    rx_fe    = 1'b0;
    rx_word  = sio_pkg::READ_ZERO;
    e_rise   = 1'b0;
    e_fall   = 1'b0;
    shift_e  = 1'b0;
    sample_e = 1'b0;
    next_q.pre      = q.pre + 8'h01;
    next_q.clk_prev = serial_clock_pin_in;
    next_q.rx_prev  = serial_in_pin_in;

    // Reserved bits are masked so they always read zero
    if (bus_req_in.wr) begin
      if (bus_req_in.addr == sio_pkg::ADDR_ASYNC_MODE) begin
        next_q.asim = bus_req_in.wdata & sio_pkg::ASYNC_WR_MASK;
      end else if (bus_req_in.addr == sio_pkg::ADDR_SYNC_MODE) begin
        next_q.csim = bus_req_in.wdata & sio_pkg::SYNC_WR_MASK;
      end else if (bus_req_in.addr == sio_pkg::ADDR_BAUD_CTRL) begin
        next_q.bgc = bus_req_in.wdata & sio_pkg::BAUD_WR_MASK;
      end else if (bus_req_in.addr == sio_pkg::ADDR_TX_DATA) begin
        push = (q.cnt != FULL_CNT);
      end
    end
    next_q.rdata = sio_pkg::READ_ZERO;
    if (bus_req_in.rd) begin
      if (bus_req_in.addr == sio_pkg::ADDR_ASYNC_MODE) begin
        next_q.rdata = q.asim;
      end else if (bus_req_in.addr == sio_pkg::ADDR_ERR_STATUS) begin
        next_q.rdata = {5'h00, q.err};
      end else if (bus_req_in.addr == sio_pkg::ADDR_SYNC_MODE) begin
        next_q.rdata = q.csim;
      end else if (bus_req_in.addr == sio_pkg::ADDR_BAUD_CTRL) begin
        next_q.rdata = q.bgc;
      end else if (bus_req_in.addr == sio_pkg::ADDR_RX_DATA) begin
        next_q.rdata = q.rxbuf;
        rd_clear     = 1'b1;
      end else if (bus_req_in.addr == sio_pkg::ADDR_BUF_STATUS) begin
        next_q.rdata = {5'h00, q.c_act | (q.t_left != 4'h0), q.rx_full,
                        q.cnt != FULL_CNT};
      end
    end

    // UART transmitter, LSB first, 16 ticks per bit
    if (!txe || csie) begin
      next_q.t_left = 4'h0;
      next_q.txd    = 1'b1;
    end else if (q.t_left == 4'h0) begin
      if (q.cnt != '0) begin
        pop           = 1'b1;
        next_q.t_sh   = 12'hfff;
        next_q.t_sh[0] = 1'b0;
        for (int i = 0; i < 8; i++) begin
          if (4'(i) < dlen) begin
            next_q.t_sh[i+1] = head[i];
          end
        end
        if (has_par) begin
          next_q.t_sh[dlen+4'h1] = par_bit(pmode, head & dmask);
        end
        next_q.t_left = rx_last + {3'h0, sl} + 4'h1;
        next_q.t_ovs  = 4'h0;
        next_q.txd    = 1'b0;
      end
    end else if (tick) begin
      next_q.t_ovs = q.t_ovs + 4'h1;
      if (q.t_ovs == sio_pkg::OVS_LAST) begin
        next_q.t_sh   = q.t_sh >> 1;
        next_q.t_left = q.t_left - 4'h1;
        next_q.txd    = (q.t_left == 4'h1) ? 1'b1 : q.t_sh[1];
      end
    end

    // UART receiver, samples mid-bit, one stop bit only
    if (!rxe || csie) begin
      next_q.r_st = sio_pkg::RX_IDLE;
    end else begin
      case (q.r_st)
        sio_pkg::RX_IDLE: begin
          if (q.rx_prev && !serial_in_pin_in) begin
            next_q.r_st  = sio_pkg::RX_RUN;
            next_q.r_ovs = 4'h0;
            next_q.r_idx = 4'h0;
          end
        end
        default: begin
          if (tick) begin
            next_q.r_ovs = q.r_ovs + 4'h1;
            if (q.r_ovs == sio_pkg::OVS_MID) begin
              next_q.r_sh[q.r_idx] = serial_in_pin_in;
              next_q.r_idx = q.r_idx + 4'h1;
              if (q.r_idx == 4'h0 && serial_in_pin_in) begin
                next_q.r_st = sio_pkg::RX_IDLE;
              end else if (q.r_idx == rx_last) begin
                next_q.r_st = sio_pkg::RX_IDLE;
                rx_done = 1'b1;
                rx_word = q.r_sh[8:1] & dmask;
                rx_fe   = ~serial_in_pin_in;
                rx_pe   = has_par && pmode != sio_pkg::PAR_ZERO &&
                          q.r_sh[dlen+4'h1] != par_bit(pmode, rx_word);
              end
            end
          end
        end
      endcase
    end

    // 3-wire clocked serial; slave edges come from the pin
    if (!csie) begin
      next_q.c_act = 1'b0;
      next_q.sck   = ~ckp;
      next_q.so    = 1'b1;
    end else if (!q.c_act) begin
      next_q.sck = ~ckp;
      if (q.cnt != '0) begin
        pop            = 1'b1;
        next_q.c_act   = 1'b1;
        next_q.c_sh    = head;
        next_q.so      = out_bit(head, dir);
        next_q.c_edges = 5'h00;
        next_q.c_bits  = 4'h0;
      end
    end else if (q.c_bits == sio_pkg::CSI_BITS &&
                 (!csck || q.c_edges == sio_pkg::CSI_EDGES)) begin
      next_q.c_act = 1'b0;
      rx_done      = 1'b1;
      rx_word      = q.c_sh;
    end else if (comm_ok) begin
      if (csck) begin
        e_rise = tick & ~q.sck;
        e_fall = tick & q.sck;
      end else begin
        e_rise = pin_rise;
        e_fall = pin_fall;
      end
      if (csck && tick) begin
        next_q.sck     = ~q.sck;
        next_q.c_edges = q.c_edges + 5'h01;
      end
      shift_e  = dap ? e_rise : e_fall;
      sample_e = dap ? e_fall : e_rise;
      if (sample_e) begin
        next_q.c_bits = q.c_bits + 4'h1;
        next_q.c_sh   = dir ? {serial_in_pin_in, q.c_sh[7:1]} :
                              {q.c_sh[6:0], serial_in_pin_in};
      end
      // First bit already stands from the load, so skip a leading shift edge
      if (shift_e && q.c_bits != 4'h0 && q.c_bits != sio_pkg::CSI_BITS) begin
        next_q.so = out_bit(q.c_sh, dir);
      end
    end

    // Receive buffer; a new word wins over a read in the same cycle
    if (rx_done) begin
      next_q.rxbuf   = rx_word;
      next_q.rx_full = 1'b1;
      next_q.err     = {rx_pe, rx_fe, q.rx_full & ~rd_clear};
    end else if (rd_clear) begin
      next_q.rx_full = 1'b0;
    end

    // Two-entry transmit buffer; a full buffer refuses the write
    if (push) begin
      next_q.txq[q.wp] = bus_req_in.wdata;
      next_q.wp        = q.wp + PW'(1);
    end
    if (pop) begin
      next_q.rp = q.rp + PW'(1);
    end
    if (push && !pop) begin
      next_q.cnt = q.cnt + CW'(1);
    end else if (pop && !push) begin
      next_q.cnt = q.cnt - CW'(1);
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q          <= '0;
      q.asim     <= sio_pkg::MODE_RESET;
      q.csim     <= sio_pkg::MODE_RESET;
      q.bgc      <= sio_pkg::MODE_RESET;
      q.txd      <= 1'b1;
      q.so       <= 1'b1;
      q.sck      <= 1'b1;
      q.clk_prev <= 1'b1;
      q.rx_prev  <= 1'b1;
      q.r_st     <= sio_pkg::RX_IDLE;
    end else begin
      q <= next_q;
    end
  end

  // Pins are released in stop mode so the port logic can own them
  assign serial_out_pin_out        = csie ? q.so : q.txd;
  assign serial_out_pin_oe_n_out   = ~(csie | txe);
  assign serial_clock_pin_out      = q.sck;
  assign serial_clock_pin_oe_n_out = ~(csie & csck);
  assign port_release_out          = stop_mode;
  assign tx_ready_out              = (q.cnt != FULL_CNT);
  assign reg_rdata_out             = q.rdata;

  chk_stop_pins: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    stop_mode |-> serial_out_pin_oe_n_out && serial_clock_pin_oe_n_out && port_release_out)
    else $error("pins driven in stop mode");
  chk_tx_halt: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !txe |=> q.txd && q.t_left == 4'h0)
    else $error("transmitter ran while disabled");
  chk_rx_halt: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (!rxe || csie) |=> q.r_st == sio_pkg::RX_IDLE)
    else $error("receiver ran while disabled");
  chk_start_low: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (txe && !csie && q.t_left == 4'h0 && q.cnt != '0) |=> !q.txd ##1 (!q.txd || !txe))
    else $error("start bit not driven low");
  chk_tick_spacing: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (tick && !q.bgc[sio_pkg::EXT_BIT] && $stable(q.bgc)) |=> !tick)
    else $error("internal tick faster than fx/2");
  chk_overrun_flag: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (rx_done && q.rx_full && !rd_clear) |=> q.err[0] && q.rx_full)
    else $error("overrun not flagged");
  chk_clock_idle: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (csie && !q.c_act) |=> q.sck == ~$past(ckp))
    else $error("serial clock not at idle level");
  chk_select_hold: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (q.c_act && !comm_ok && q.c_bits != sio_pkg::CSI_BITS) |=> $stable(q.c_sh) && $stable(q.sck))
    else $error("transfer moved while deselected");
  chk_queue_full: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (q.cnt == FULL_CNT && !pop) |=> $stable(q.wp) && !tx_ready_out)
    else $error("write accepted into full buffer");
endmodule

/* testbench/sio_peer.sv */
module sio_peer (
  input  wire logic core_clk_in,
  input  wire logic sck_level_in,
  input  wire logic so_in,
  output logic      si_out,
  output logic      ext_clk_out,
  output logic      mck_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    si_out = 1'b1;
    ext_clk_out = 1'b0;
    mck_out = 1'b1;
  end

  // Clocks a slave transfer: data changes on the fall, sampled on the rise
  task automatic spi_master(input logic [7:0] tx, output logic [7:0] got);
    for (int i = 7; i >= 0; i--) begin
      repeat (3) @(posedge core_clk_in);
      #1 mck_out = 1'b0;
      si_out = tx[i];
      repeat (3) @(posedge core_clk_in);
      #1 mck_out = 1'b1;
      got[i] = so_in;
    end
  endtask

  // Baud oscillator, gated at the pin by the bench
  always begin
    repeat (2) @(posedge core_clk_in);
    #1 ext_clk_out = ~ext_clk_out;
  end

  task automatic uart_send(input logic [11:0] bits, input int n, input int per);
    for (int i = 0; i < n; i++) begin
      si_out = bits[i];
      repeat (per) @(posedge core_clk_in);
      #1;
    end
    si_out = 1'b1;
  endtask

  task automatic uart_recv(input int n, input int per, output logic [11:0] bits,
                           output bit tmo);
    int w;
    bits = 12'hfff;
    w = 0;
    while (so_in !== 1'b0 && w < 4000) begin
      @(posedge core_clk_in);
      w++;
    end
    tmo = (w >= 4000);
    repeat (per / 2) @(posedge core_clk_in);
    for (int i = 0; i < n; i++) begin
      #1 bits[i] = so_in;
      if (i + 1 < n) repeat (per) @(posedge core_clk_in);
    end
  endtask

  // Sends MSB first; the first shift edge is skipped when it comes before any sample
  task automatic spi_slave(input logic [7:0] tx, input logic dap, output logic [7:0] got,
                           output int span, output bit tmo);
    logic prev;
    int   k;
    int   w;
    int   t0;
    k = 0;
    w = 0;
    t0 = 0;
    got = 8'h00;
    si_out = tx[7];
    prev = sck_level_in;
    while (k < 8 && w < 3000) begin
      @(posedge core_clk_in);
      #1;
      w++;
      if (sck_level_in !== prev) begin
        prev = sck_level_in;
        if (prev === ~dap) begin
          got[7 - k] = so_in;
          if (k == 0) t0 = w;
          k++;
        end else if (k > 0) si_out = tx[7 - k];
      end
    end
    span = w - t0;
    tmo = (k < 8);
    si_out = ~si_out;
  endtask
endmodule

/* testbench/serial_if_uart_sio_config_bench.sv */
module serial_if_uart_sio_config_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  core_clk_in = 1'b0;
  logic                  rst_n_in = 1'b0;
  sio_pkg::sio_bus_req_t req = '0;
  logic                  ss_level = 1'b1;
  logic                  ext_en = 1'b0;
  logic [7:0]            rdata;
  logic                  tx_ready, sck_out, sck_oe_n, so_out, so_oe_n, port_release;
  logic                  si, ext_ck, mck, ck_level;
  int                    n_fail = 0;
  int                    total_checks = 0;

  always #10 core_clk_in = ~core_clk_in;
  // Peer clock idles high, like the pin's pull-up
  assign ck_level = !sck_oe_n ? sck_out : (ext_en ? ext_ck : mck);

  sio_serial_if dut (
    .core_clk_in               (core_clk_in),
    .rst_n_in                  (rst_n_in),
    .bus_req_in                (req),
    .reg_rdata_out             (rdata),
    .tx_ready_out              (tx_ready),
    .serial_clock_pin_in       (ck_level),
    .serial_clock_pin_out      (sck_out),
    .serial_clock_pin_oe_n_out (sck_oe_n),
    .serial_out_pin_out        (so_out),
    .serial_out_pin_oe_n_out   (so_oe_n),
    .serial_in_pin_in          (si),
    .slave_select_pin_in       (ss_level),
    .port_release_out          (port_release)
  );

  sio_peer peer (
    .core_clk_in  (core_clk_in),
    .sck_level_in (ck_level),
    .so_in        (so_out),
    .si_out       (si),
    .ext_clk_out  (ext_ck),
    .mck_out      (mck)
  );

  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic guard(input bit tmo);
    if (tmo) begin
      n_fail++;
      $display("Error wait expected done seen timeout");
      end_of_test();
    end
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge core_clk_in);
    #1;
  endtask

  // An idle cycle follows each access so wr and rd never change twice at once
  task automatic bus(input logic [15:0] a, input logic [7:0] d, input logic w,
                     output logic [7:0] q);
    req.addr = a;
    req.wdata = d;
    req.wr = w;
    req.rd = !w;
    idle(1);
    q = rdata;
    req.wr = 1'b0;
    req.rd = 1'b0;
    idle(1);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(a, d, 1'b1, q);
  endtask

  task automatic rdchk(input string what, input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(a, 8'h00, 1'b0, q);
    check(what, q, exp);
  endtask

  function automatic logic [7:0] rev(input logic [7:0] x);
    for (int i = 0; i < 8; i++) rev[i] = x[7 - i];
  endfunction

  function automatic logic [11:0] frame(input logic [7:0] m, input logic [7:0] d, output int n);
    logic [7:0] dm;
    frame = 12'hffe;
    dm = m[3] ? d : {1'b0, d[6:0]};
    n = m[3] ? 9 : 8;
    for (int i = 0; i < n - 1; i++) frame[i + 1] = dm[i];
    if (m[5:4] != 2'h0) begin
      frame[n] = (m[5:4] == 2'h1) ? 1'b0 : (^dm ^ !m[4]);
      n++;
    end
    n = n + 1 + m[2];
  endfunction

  task automatic tx_case(input logic [7:0] m, input logic [7:0] d, input int per);
    logic [11:0] got, exp;
    bit          tmo;
    int          n;
    exp = frame(m, d, n);
    wr(sio_pkg::ADDR_ASYNC_MODE, m);
    wr(sio_pkg::ADDR_TX_DATA, d);
    peer.uart_recv(n, per, got, tmo);
    guard(tmo);
    check("tx frame", got, exp);
    idle(80);
  endtask

  task automatic rx_send(input logic [7:0] m, input logic [7:0] d, input logic [11:0] flip);
    logic [11:0] f;
    int          n;
    f = frame(m, d, n) ^ flip;
    peer.uart_send(f, n, 32);
    idle(4);
  endtask

  task automatic t_regs();
    rdchk("async reset", sio_pkg::ADDR_ASYNC_MODE, 8'h00);
    rdchk("sync reset", sio_pkg::ADDR_SYNC_MODE, 8'h00);
    wr(sio_pkg::ADDR_ASYNC_MODE, 8'h3f);
    rdchk("async mask", sio_pkg::ADDR_ASYNC_MODE, 8'h3c);
    wr(sio_pkg::ADDR_SYNC_MODE, 8'h7e);
    rdchk("sync mask", sio_pkg::ADDR_SYNC_MODE, 8'h4e);
    check("stop mode", port_release, 1'b1);
    rdchk("unmapped", 16'hff7e, 8'h00);
    wr(sio_pkg::ADDR_SYNC_MODE, 8'h00);
  endtask

  task automatic t_tx();
    logic [11:0] got;
    bit          tmo;
    int          n;
    wr(sio_pkg::ADDR_BAUD_CTRL, 8'h00);
    wr(sio_pkg::ADDR_ASYNC_MODE, 8'h08);
    wr(sio_pkg::ADDR_TX_DATA, 8'h5a);
    wr(sio_pkg::ADDR_TX_DATA, 8'ha3);
    check("tx full", tx_ready, 1'b0);
    wr(sio_pkg::ADDR_ASYNC_MODE, 8'h88);
    check("tx drive", so_oe_n, 1'b0);
    check("tx active", port_release, 1'b0);
    peer.uart_recv(10, 32, got, tmo);
    guard(tmo);
    check("tx first", got, frame(8'h88, 8'h5a, n));
    peer.uart_recv(10, 32, got, tmo);
    guard(tmo);
    check("tx second", got, frame(8'h88, 8'ha3, n));
    check("tx space", tx_ready, 1'b1);
    idle(80);
    for (int pm = 0; pm < 4; pm++) tx_case(8'h88 | 8'(pm << 4), 8'h6b, 32);
    tx_case(8'ha4, 8'hc5, 32);
    wr(sio_pkg::ADDR_BAUD_CTRL, 8'h10);
    tx_case(8'h8c, 8'h96, 64);
    wr(sio_pkg::ADDR_BAUD_CTRL, 8'h80);
    ext_en = 1'b1;
    tx_case(8'h88, 8'h39, 64);
    ext_en = 1'b0;
    wr(sio_pkg::ADDR_BAUD_CTRL, 8'h00);
  endtask

  task automatic t_rx();
    wr(sio_pkg::ADDR_ASYNC_MODE, 8'h48);
    rx_send(8'h48, 8'h3c, 12'h000);
    rdchk("rx data", sio_pkg::ADDR_RX_DATA, 8'h3c);
    rdchk("rx clean", sio_pkg::ADDR_ERR_STATUS, 8'h00);
    rx_send(8'h48, 8'h7e, 12'h200);
    rdchk("rx frame", sio_pkg::ADDR_ERR_STATUS, 8'h02);
    rdchk("rx fe data", sio_pkg::ADDR_RX_DATA, 8'h7e);
    wr(sio_pkg::ADDR_ASYNC_MODE, 8'h68);
    rx_send(8'h68, 8'h01, 12'h200);
    rdchk("rx parity", sio_pkg::ADDR_ERR_STATUS, 8'h04);
    rdchk("rx pe data", sio_pkg::ADDR_RX_DATA, 8'h01);
    wr(sio_pkg::ADDR_ASYNC_MODE, 8'h58);
    rx_send(8'h58, 8'h01, 12'h200);
    rdchk("rx unchecked", sio_pkg::ADDR_ERR_STATUS, 8'h00);
    rdchk("rx zp data", sio_pkg::ADDR_RX_DATA, 8'h01);
    // Second stop slot falls in the next start bit
    wr(sio_pkg::ADDR_ASYNC_MODE, 8'h4c);
    rx_send(8'h48, 8'h11, 12'h000);
    rx_send(8'h48, 8'h22, 12'h000);
    rdchk("rx overrun", sio_pkg::ADDR_ERR_STATUS, 8'h01);
    rdchk("rx last", sio_pkg::ADDR_RX_DATA, 8'h22);
    wr(sio_pkg::ADDR_ASYNC_MODE, 8'h08);
    rx_send(8'h48, 8'h77, 12'h000);
    rdchk("rx off", sio_pkg::ADDR_BUF_STATUS, 8'h01);
  endtask

  task automatic t_csi(input logic [7:0] m, input logic [7:0] bgc, input logic [7:0] d);
    logic [7:0] got;
    int         span;
    bit         tmo;
    wr(sio_pkg::ADDR_BAUD_CTRL, bgc);
    wr(sio_pkg::ADDR_SYNC_MODE, m);
    check("sck idle", sck_out, !m[0]);
    check("sck drive", sck_oe_n, 1'b0);
    fork
      wr(sio_pkg::ADDR_TX_DATA, d);
      peer.spi_slave(~d, m[3], got, span, tmo);
    join
    guard(tmo);
    check("csi out", got, m[2] ? rev(d) : d);
    check("csi rate", span[11:0], 12'(7 << (bgc[6:4] + 2)));
    idle(40);
    check("sck end", sck_out, !m[0]);
    rdchk("csi in", sio_pkg::ADDR_RX_DATA, m[2] ? rev(~d) : ~d);
  endtask

  task automatic t_ss();
    logic [7:0] got;
    int         span;
    int         ch;
    bit         tmo;
    wr(sio_pkg::ADDR_SYNC_MODE, 8'hc2);
    wr(sio_pkg::ADDR_TX_DATA, 8'h3c);
    ch = 0;
    repeat (30) begin
      idle(1);
      if (sck_out !== 1'b1) ch++;
    end
    check("ss hold", ch[11:0], 12'h000);
    ss_level = 1'b0;
    peer.spi_slave(8'h00, 1'b0, got, span, tmo);
    guard(tmo);
    check("ss run", got, 8'h3c);
    idle(40);
  endtask

  task automatic t_slave();
    logic [7:0] got;
    wr(sio_pkg::ADDR_BAUD_CTRL, 8'h70);
    wr(sio_pkg::ADDR_SYNC_MODE, 8'h80);
    check("slave sck oe", sck_oe_n, 1'b1);
    wr(sio_pkg::ADDR_TX_DATA, 8'h9d);
    peer.spi_master(8'h4b, got);
    idle(4);
    check("slave out", got, 8'h9d);
    rdchk("slave in", sio_pkg::ADDR_RX_DATA, 8'h4b);
    wr(sio_pkg::ADDR_BAUD_CTRL, 8'h00);
  endtask

  initial begin
    idle(6);
    check("rst release", port_release, 1'b1);
    check("rst so oe", so_oe_n, 1'b1);
    idle(6);
    rst_n_in = 1'b1;
    t_regs();
    t_tx();
    t_rx();
    t_csi(8'h82, 8'h00, 8'ha6);
    t_csi(8'h8a, 8'h00, 8'h5b);
    t_csi(8'h8f, 8'h20, 8'hc4);
    t_ss();
    t_slave();
    wr(sio_pkg::ADDR_SYNC_MODE, 8'h00);
    check("stop release", port_release, 1'b1);
    check("stop sck oe", sck_oe_n, 1'b1);
    check("stop so oe", so_oe_n, 1'b1);
    end_of_test();
  end
endmodule
